// ### rtl/lsrc_pkg.sv
// limit switch relay control: shared constants and types
// assumes a single 125 MHz clock and a plain strobe-based register port
package lsrc_pkg;

  // ********************************
  // clock and sampling
  // ********************************
  localparam int unsigned CLK_PERIOD_NS    = 8;
  // one evaluation every 10 us keeps excursions of 50 us visible
  localparam int unsigned SAMPLE_PERIOD_NS = 10000;
  localparam int unsigned SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // ********************************
  // widths
  // ********************************
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned VALUE_W = 16;
  localparam int unsigned DELAY_W = 16;

  // ********************************
  // register offsets (byte addresses)
  // ********************************
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_UPPER_LIMIT = 8'h04;
  localparam logic [7:0] OFS_UPPER_HYST  = 8'h08;
  localparam logic [7:0] OFS_LOWER_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_LOWER_HYST  = 8'h10;
  localparam logic [7:0] OFS_DELAY_ON    = 8'h14;
  localparam logic [7:0] OFS_DELAY_OFF   = 8'h18;
  localparam logic [7:0] OFS_STATE       = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h24;

  // ********************************
  // control register fields
  // ********************************
  localparam int unsigned CTRL_SEL_LSB   = 0;
  localparam int unsigned CTRL_FUNC_LSB  = 2;
  localparam int unsigned CTRL_RELAY_LSB = 4;
  localparam int unsigned CTRL_CLOSE_BIT = 6;
  localparam int unsigned CTRL_NC_BIT    = 7;
  localparam int unsigned CTRL_W         = 8;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // ********************************
  // interrupt bits
  // ********************************
  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_ACTIVATED  = 0;
  localparam int unsigned IRQ_RELEASED   = 1;
  localparam int unsigned IRQ_POWER_CHG  = 2;
  localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;

  // ********************************
  // enumerations
  // ********************************
  typedef enum logic [1:0] {
    LSRC_SEL_NONE    = 2'b00,
    LSRC_SEL_VOLTAGE = 2'b01,
    LSRC_SEL_CURRENT = 2'b10,
    LSRC_SEL_POWER   = 2'b11
  } lsrc_sel_t;

  typedef enum logic [1:0] {
    LSRC_FN_RISE   = 2'b00,
    LSRC_FN_FALL   = 2'b01,
    LSRC_FN_ENTER  = 2'b10,
    LSRC_FN_LEAVE  = 2'b11
  } lsrc_func_t;

  typedef enum logic [1:0] {
    LSRC_RLY_WARN  = 2'b00,
    LSRC_RLY_RUN   = 2'b01,
    LSRC_RLY_READY = 2'b10
  } lsrc_relay_t;

  typedef enum logic [1:0] {
    LSRC_PS_OFF  = 2'b00,
    LSRC_PS_WAIT = 2'b01,
    LSRC_PS_ON   = 2'b10
  } lsrc_pstate_t;

endpackage : lsrc_pkg

// ### rtl/lsrc_delay_counter.sv
// limit switch relay control: one switching-delay counter
// assumes i_tick pulses once per sampling period on the same clock
module lsrc_delay_counter #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  // control
  input  wire logic             i_tick,
  input  wire logic             i_up,
  input  wire logic             i_down,
  input  wire logic             i_clear,
  input  wire logic [WIDTH-1:0] i_limit,
  // status
  output logic      [WIDTH-1:0] o_count,
  output logic                  o_done
);

  logic [WIDTH:0] count_plus;

  assign count_plus = {1'b0, o_count} + {{WIDTH{1'b0}}, 1'b1};

  // a zero limit completes on the first active sample
  assign o_done = i_tick & i_up & (count_plus >= {1'b0, i_limit});

  always_ff @(posedge i_mclk)
  begin
    if (i_rst || i_clear)
    begin
      o_count <= '0;
    end
    else if (i_tick && i_up && !o_done)
    begin
      o_count <= count_plus[WIDTH-1:0];
    end
    // down saturates at zero
    else if (i_tick && i_down && (o_count != '0))
    begin
      o_count <= o_count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule : lsrc_delay_counter

// ### rtl/lsrc_top.sv
// limit switch relay control: supervisor, power control and relay mapping
// assumes synchronous measured values and a strobe register port
// the relay drivers and the power stage sit outside this block

// What this block does
// RULE1: monitors one selectable quantity: voltage, current or power
// RULE2: violating the limit condition switches the assigned relay
// RULE3: assigned relay selectable: warning, run or ready/alarm (NC or NO)
// RULE4: functions: above threshold, below threshold, enter window, leave window
// RULE5: each threshold has its own hysteresis band holding the decision
// RULE6: zero hysteresis compares against the bare threshold
// RULE7: programmable switching delays suppress short transients
// RULE8: quantity is sampled periodically; sub-50 us excursions may be missed
// RULE9: activation counter counts up while value sits in active range
// RULE10: counter counts down beyond hysteresis, up again on re-entry
// RULE11: reaching the delay limit switches relay per configured polarity
// RULE12: active-to-inactive uses a separate counter with its own delay
// RULE13: power-on request high turns stage on, open turns it off; the code turns the stage on only once i_device_ready is also high
// RULE14: defaults: relay one ready, relay two power-on, relay three warning
// RULE15: relay state in inactive range is inverse of active setting
// RULE16: selection none disables supervisor; it drives no relay
// RULE17: counters saturate at zero and clear after each transition
// RULE18: comparisons and counter updates happen once per sampling period
module lsrc_top #(
  parameter int unsigned VALUE_W = lsrc_pkg::VALUE_W,
  parameter int unsigned DELAY_W = lsrc_pkg::DELAY_W
) (
  // clock and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  // register port
  input  wire logic [lsrc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [lsrc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [lsrc_pkg::DATA_W-1:0] o_rdata,
  // measured values, signed
  input  wire logic [VALUE_W-1:0]          i_voltage,
  input  wire logic [VALUE_W-1:0]          i_current,
  input  wire logic [VALUE_W-1:0]          i_power,
  // device status
  input  wire logic                        i_power_on_req,
  input  wire logic                        i_device_ready,
  input  wire logic                        i_warning,
  // power stage and relays, 1 = contact closed / coil energised
  output logic                             o_power_stage_on,
  output logic                             o_relay_output_one,
  output logic                             o_relay_output_two,
  output logic                             o_relay_output_three,
  // interrupt
  output logic                             o_irq
);

  // ********************************
  // registers
  // ********************************
  logic [lsrc_pkg::CTRL_W-1:0] ctrl;
  logic [VALUE_W-1:0]          upper_limit;
  logic [VALUE_W-1:0]          upper_hyst;
  logic [VALUE_W-1:0]          lower_limit;
  logic [VALUE_W-1:0]          lower_hyst;
  logic [DELAY_W-1:0]          delay_on;
  logic [DELAY_W-1:0]          delay_off;
  logic [lsrc_pkg::IRQ_W-1:0]  irq_status;
  logic [lsrc_pkg::IRQ_W-1:0]  irq_mask;

  lsrc_pkg::lsrc_sel_t         sel;
  lsrc_pkg::lsrc_func_t        func;
  lsrc_pkg::lsrc_relay_t       relay_sel;
  logic                        close_when_active;
  logic                        ready_relay_nc;

  assign sel               = lsrc_pkg::lsrc_sel_t'(
                               ctrl[lsrc_pkg::CTRL_SEL_LSB +: 2]);
  assign func              = lsrc_pkg::lsrc_func_t'(
                               ctrl[lsrc_pkg::CTRL_FUNC_LSB +: 2]);
  assign relay_sel         = lsrc_pkg::lsrc_relay_t'(
                               ctrl[lsrc_pkg::CTRL_RELAY_LSB +: 2]);
  assign close_when_active = ctrl[lsrc_pkg::CTRL_CLOSE_BIT];
  assign ready_relay_nc    = ctrl[lsrc_pkg::CTRL_NC_BIT];

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ctrl        <= lsrc_pkg::CTRL_RESET;
      upper_limit <= '0;
      upper_hyst  <= '0;
      lower_limit <= '0;
      lower_hyst  <= '0;
      delay_on    <= '0;
      delay_off   <= '0;
      irq_mask    <= lsrc_pkg::IRQ_MASK_RESET;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        lsrc_pkg::OFS_CTRL:
          ctrl <= i_wdata[lsrc_pkg::CTRL_W-1:0];
        lsrc_pkg::OFS_UPPER_LIMIT:
          upper_limit <= i_wdata[VALUE_W-1:0];
        lsrc_pkg::OFS_UPPER_HYST:
          upper_hyst <= i_wdata[VALUE_W-1:0];
        lsrc_pkg::OFS_LOWER_LIMIT:
          lower_limit <= i_wdata[VALUE_W-1:0];
        lsrc_pkg::OFS_LOWER_HYST:
          lower_hyst <= i_wdata[VALUE_W-1:0];
        lsrc_pkg::OFS_DELAY_ON:
          delay_on <= i_wdata[DELAY_W-1:0];
        lsrc_pkg::OFS_DELAY_OFF:
          delay_off <= i_wdata[DELAY_W-1:0];
        lsrc_pkg::OFS_IRQ_MASK:
          irq_mask <= i_wdata[lsrc_pkg::IRQ_W-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // ********************************
  // sampling tick
  // ********************************
  logic [15:0] tick_cnt;
  logic        tick;

  // RULE8: periodic sampling
  assign tick = (tick_cnt == 16'(lsrc_pkg::SAMPLE_CYCLES - 1));

  always_ff @(posedge i_mclk)
  begin
    if (i_rst || tick)
    begin
      tick_cnt <= '0;
    end
    else
    begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // ********************************
  // monitored quantity
  // ********************************
  logic signed [VALUE_W:0] value;
  logic signed [VALUE_W:0] next_value;
  logic                    enabled;

  // RULE16: none disables
  assign enabled = (sel != lsrc_pkg::LSRC_SEL_NONE);

  // RULE1: quantity select
  always_comb
  begin
    next_value = value;
    unique case (sel)
      lsrc_pkg::LSRC_SEL_VOLTAGE:
        next_value = {i_voltage[VALUE_W-1], i_voltage};
      lsrc_pkg::LSRC_SEL_CURRENT:
        next_value = {i_current[VALUE_W-1], i_current};
      lsrc_pkg::LSRC_SEL_POWER:   next_value = {i_power[VALUE_W-1], i_power};
      lsrc_pkg::LSRC_SEL_NONE:    next_value = '0;
    endcase
  end

  // RULE18: one sample each period
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      value <= '0;
    end
    else if (tick)
    begin
      value <= next_value;
    end
  end

  // ********************************
  // threshold comparisons
  // ********************************
  // two extra bits so limit +/- hysteresis never wraps
  logic signed [VALUE_W+1:0] v;
  logic signed [VALUE_W+1:0] up_lim;
  logic signed [VALUE_W+1:0] lo_lim;
  logic signed [VALUE_W+1:0] up_rel;
  logic signed [VALUE_W+1:0] lo_rel;
  logic signed [VALUE_W+1:0] up_wide;
  logic signed [VALUE_W+1:0] lo_wide;
  logic                      cond_active;
  logic                      cond_inactive;

  assign v      = {value[VALUE_W], value};
  assign up_lim = {{2{upper_limit[VALUE_W-1]}}, upper_limit};
  assign lo_lim = {{2{lower_limit[VALUE_W-1]}}, lower_limit};
  // RULE5: hysteresis bands
  // RULE6: zero band is bare threshold
  assign up_rel  = up_lim - {2'b00, upper_hyst};
  assign lo_rel  = lo_lim + {2'b00, lower_hyst};
  assign up_wide = up_lim + {2'b00, upper_hyst};
  assign lo_wide = lo_lim - {2'b00, lower_hyst};

  // between the two conditions the decision holds
  // RULE4: four functions
  always_comb
  begin
    cond_active   = 1'b0;
    cond_inactive = 1'b1;
    unique case (func)
      lsrc_pkg::LSRC_FN_RISE:
      begin
        cond_active   = (v > up_lim);
        cond_inactive = (v <= up_rel);
      end
      lsrc_pkg::LSRC_FN_FALL:
      begin
        cond_active   = (v < lo_lim);
        cond_inactive = (v >= lo_rel);
      end
      lsrc_pkg::LSRC_FN_ENTER:
      begin
        cond_active   = (v >= lo_lim) && (v <= up_lim);
        cond_inactive = (v < lo_wide) || (v > up_wide);
      end
      lsrc_pkg::LSRC_FN_LEAVE:
      begin
        cond_active   = (v > up_lim) || (v < lo_lim);
        cond_inactive = (v <= up_rel) && (v >= lo_rel);
      end
    endcase
  end

  // ********************************
  // switching delays
  // ********************************
  logic               sup_active;
  logic               on_done;
  logic               off_done;
  logic [DELAY_W-1:0] on_count;
  logic [DELAY_W-1:0] off_count;

  // RULE7: programmable delays
  // RULE9: up while active
  // RULE10: down past hysteresis
  lsrc_delay_counter #(
    .WIDTH   (DELAY_W)
  ) u_on_delay (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_tick  (tick & enabled & ~sup_active),
    .i_up    (cond_active),
    .i_down  (cond_inactive),
    .i_clear (on_done | sup_active | ~enabled),
    .i_limit (delay_on),
    .o_count (on_count),
    .o_done  (on_done)
  );

  // RULE12: separate release counter
  lsrc_delay_counter #(
    .WIDTH   (DELAY_W)
  ) u_off_delay (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_tick  (tick & enabled & sup_active),
    .i_up    (cond_inactive),
    .i_down  (cond_active),
    .i_clear (off_done | ~sup_active | ~enabled),
    .i_limit (delay_off),
    .o_count (off_count),
    .o_done  (off_done)
  );

  // RULE17: counters cleared on transition
  // RULE11: delay reached switches state
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !enabled)
    begin
      sup_active <= 1'b0;
    end
    else if (on_done)
    begin
      sup_active <= 1'b1;
    end
    else if (off_done)
    begin
      sup_active <= 1'b0;
    end
  end

  // ********************************
  // power stage control
  // ********************************
  lsrc_pkg::lsrc_pstate_t pstate;
  lsrc_pkg::lsrc_pstate_t next_pstate;
  logic                   req_q;

  // RULE13: request goes through a wait state that holds until device ready, or returns to off if the request drops
  always_comb
  begin
    next_pstate = pstate;
    unique case (pstate)
      lsrc_pkg::LSRC_PS_OFF:
        if (i_power_on_req)
          next_pstate = lsrc_pkg::LSRC_PS_WAIT;
      lsrc_pkg::LSRC_PS_WAIT:
        if (!i_power_on_req)
          next_pstate = lsrc_pkg::LSRC_PS_OFF;
        else if (i_device_ready)
          next_pstate = lsrc_pkg::LSRC_PS_ON;
      lsrc_pkg::LSRC_PS_ON:
        if (!i_power_on_req)
          next_pstate = lsrc_pkg::LSRC_PS_OFF;
      default:
        next_pstate = lsrc_pkg::LSRC_PS_OFF;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      pstate <= lsrc_pkg::LSRC_PS_OFF;
      req_q  <= 1'b0;
    end
    else
    begin
      pstate <= next_pstate;
      req_q  <= i_power_on_req;
    end
  end

  assign o_power_stage_on = (pstate == lsrc_pkg::LSRC_PS_ON);

  // ********************************
  // relay mapping
  // ********************************
  logic sup_level;
  logic next_relay_one;
  logic next_relay_two;
  logic next_relay_three;

  // RULE15: inactive is the inverse
  assign sup_level = sup_active ? close_when_active : ~close_when_active;

  always_comb
  begin
    // RULE14: default relay functions
    next_relay_one   = i_device_ready ^ ready_relay_nc;
    next_relay_two   = i_power_on_req;
    next_relay_three = i_warning;
    // RULE2: supervisor takes its relay
    // RULE3: relay selection
    if (enabled)
    begin
      unique case (relay_sel)
        lsrc_pkg::LSRC_RLY_WARN:  next_relay_three = sup_level;
        lsrc_pkg::LSRC_RLY_RUN:   next_relay_two   = sup_level;
        lsrc_pkg::LSRC_RLY_READY: next_relay_one   = sup_level ^ ready_relay_nc;
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_relay_output_one   <= 1'b0;
      o_relay_output_two   <= 1'b0;
      o_relay_output_three <= 1'b0;
    end
    else
    begin
      o_relay_output_one   <= next_relay_one;
      o_relay_output_two   <= next_relay_two;
      o_relay_output_three <= next_relay_three;
    end
  end

  // ********************************
  // interrupts and read back
  // ********************************
  logic [lsrc_pkg::IRQ_W-1:0] irq_set;
  logic                       irq_rd;

  assign irq_set[lsrc_pkg::IRQ_ACTIVATED] = on_done;
  assign irq_set[lsrc_pkg::IRQ_RELEASED]  = off_done;
  assign irq_set[lsrc_pkg::IRQ_POWER_CHG] = req_q ^ i_power_on_req;
  assign irq_rd = i_rd && (i_addr == lsrc_pkg::OFS_IRQ_STATUS);

  // a new event in the clearing read cycle stays set
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      irq_status <= '0;
    end
    else
    begin
      irq_status <= (irq_rd ? '0 : irq_status) | irq_set;
    end
  end

  assign o_irq = |(irq_status & irq_mask);

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_rdata <= '0;
    end
    else if (i_rd)
    begin
      unique case (i_addr)
        lsrc_pkg::OFS_CTRL:        o_rdata <= 32'(ctrl);
        lsrc_pkg::OFS_UPPER_LIMIT: o_rdata <= 32'(upper_limit);
        lsrc_pkg::OFS_UPPER_HYST:  o_rdata <= 32'(upper_hyst);
        lsrc_pkg::OFS_LOWER_LIMIT: o_rdata <= 32'(lower_limit);
        lsrc_pkg::OFS_LOWER_HYST:  o_rdata <= 32'(lower_hyst);
        lsrc_pkg::OFS_DELAY_ON:    o_rdata <= 32'(delay_on);
        lsrc_pkg::OFS_DELAY_OFF:   o_rdata <= 32'(delay_off);
        lsrc_pkg::OFS_STATE:
          o_rdata <= {off_count, on_count[DELAY_W-1:8], 1'b0,
                      o_relay_output_three, o_relay_output_two,
                      o_relay_output_one, o_power_stage_on,
                      cond_inactive, cond_active, sup_active};
        lsrc_pkg::OFS_IRQ_STATUS:  o_rdata <= 32'(irq_status);
        lsrc_pkg::OFS_IRQ_MASK:    o_rdata <= 32'(irq_mask);
        default:                   o_rdata <= '0;
      endcase
    end
    else
    begin
      o_rdata <= '0;
    end
  end

endmodule : lsrc_top

// ### verification/lsrc_top_monitor.sv
// limit switch relay control: port-level checker
// assumes only the ports of lsrc_top; bound in at the foot of this file
module lsrc_top_monitor (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst,
  // register port
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // status in, stage and relays out
  input wire logic        i_power_on_req,
  input wire logic        i_device_ready,
  input wire logic        i_warning,
  input wire logic        o_power_stage_on,
  input wire logic        o_relay_output_one,
  input wire logic        o_relay_output_two,
  input wire logic        o_relay_output_three,
  input wire logic        o_irq
);
  // ********************************
  // register shadows
  // ********************************
  // a copy one cycle old lets us wait until a write has settled
  logic [7:0] ctrl;
  logic [7:0] ctrl_d;
  logic [2:0] mask;
  logic [2:0] mask_d;
  wire        quiet = ctrl[1:0] == 2'h0 && ctrl_d == ctrl;
  always_ff @(posedge i_mclk)
  begin
    ctrl_d <= i_rst ? 8'h00 : ctrl;
    if (i_rst)
      ctrl <= 8'h00;
    else if (i_wr && i_addr == lsrc_pkg::OFS_CTRL)
      ctrl <= i_wdata[7:0];
  end
  always_ff @(posedge i_mclk)
  begin
    mask_d <= i_rst ? 3'h0 : mask;
    if (i_rst)
      mask <= 3'h0;
    else if (i_wr && i_addr == lsrc_pkg::OFS_IRQ_MASK)
      mask <= i_wdata[2:0];
  end
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  sequence s_on_held;
    (i_power_on_req && i_device_ready) [*4];
  endsequence
  property p_default_relays;
    quiet && !$past(i_rst) |->
      o_relay_output_two == $past(i_power_on_req) &&
      o_relay_output_three == $past(i_warning) &&
      o_relay_output_one == ($past(i_device_ready) ^ ctrl[7]);
  endproperty
  a_default_relays: assert property (p_default_relays)
    else $error("default relay mapping wrong");
  property p_stage_off;
    !i_power_on_req |-> ##2 !o_power_stage_on;
  endproperty
  a_stage_off: assert property (p_stage_off)
    else $error("stage stays on after request dropped");
  property p_stage_needs_req;
    o_power_stage_on |-> $past(i_power_on_req, 2);
  endproperty
  a_stage_needs_req: assert property (p_stage_needs_req)
    else $error("stage on without request");
  property p_stage_on;
    s_on_held |-> o_power_stage_on;
  endproperty
  a_stage_on: assert property (p_stage_on)
    else $error("stage not on with request and ready");
  property p_stage_ready;
    $rose(o_power_stage_on) |->
      $past(i_device_ready) || $past(i_device_ready, 2);
  endproperty
  a_stage_ready: assert property (p_stage_ready)
    else $error("stage on without ready");
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
  property p_unmapped;
    $past(i_rd) && $past(i_addr) > 8'h24 |-> o_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_irq_masked;
    mask == 3'h0 && mask_d == 3'h0 |-> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt with all masked");
  property p_irq_power;
    mask[2] && mask_d[2] && $changed(i_power_on_req) |-> ##[1:3] o_irq;
  endproperty
  a_irq_power: assert property (p_irq_power)
    else $error("no interrupt on request change");
endmodule : lsrc_top_monitor

bind lsrc_top lsrc_top_monitor u_monitor (
  .i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_power_on_req, .i_device_ready, .i_warning, .o_power_stage_on,
  .o_relay_output_one, .o_relay_output_two, .o_relay_output_three,
  .o_irq
);

// ### verification/lsrc_field_model.sv
// limit switch relay control: field side, on/off contact and status lines
// assumes bench commands; lines change just after a rising edge
module lsrc_field_model (
  // clock
  input  wire logic i_mclk,
  // bench commands
  input  wire logic i_cmd_on,
  input  wire logic i_cmd_ready,
  input  wire logic i_cmd_warn,
  // lines into the block
  output logic      o_power_on_req,
  output logic      o_device_ready,
  output logic      o_warning
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
    {o_power_on_req, o_device_ready, o_warning} = 3'b000;
  always @(posedge i_mclk)
  begin
    o_power_on_req <= i_cmd_on;
    o_device_ready <= i_cmd_ready;
    o_warning      <= i_cmd_warn;
  end
endmodule : lsrc_field_model

// ### verification/tb.sv
// limit switch relay control: self-checking bench
// assumes lsrc_top, the field model and the bound checker
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = int'(lsrc_pkg::SAMPLE_CYCLES);
  localparam int U  = 1000;
  localparam int L  = -1000;
  localparam int H  = 100;
  logic        i_mclk, i_rst, i_wr, i_rd, rd_d;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [15:0] i_voltage, i_current, i_power;
  logic        req, rdy, warn, cmd_on, cmd_rdy, cmd_warn;
  logic        o_power_stage_on, o_irq, r1, r2, r3, lv;
  logic [63:0] exp_q[$];
  logic [63:0] exp_n;
  wire  [4:0]  outs = {o_irq, o_power_stage_on, r3, r2, r1};
  int          num_errors, cmp_count, cyc, s, rs, r, act, ina;
  lsrc_top dut (
    .i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_voltage, .i_current, .i_power, .i_power_on_req(req),
    .i_device_ready(rdy), .i_warning(warn), .o_power_stage_on,
    .o_relay_output_one(r1), .o_relay_output_two(r2),
    .o_relay_output_three(r3), .o_irq);
  lsrc_field_model u_field (
    .i_mclk, .i_cmd_on(cmd_on), .i_cmd_ready(cmd_rdy),
    .i_cmd_warn(cmd_warn), .o_power_on_req(req), .o_device_ready(rdy),
    .o_warning(warn));
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // ********************************
  // compare and bus tasks
  // ********************************
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED rdata expected %h seen %h", e, g);
    end
  endtask : chk_word
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back({m, e & m});
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
  endtask : rd
  // outputs are looked at on the falling edge, well clear of updates
  task automatic wait_out(input int idx, input logic e, input int n);
    @(negedge i_mclk);
    for (int k = 0; k < n && outs[idx] !== e; k++)
      @(negedge i_mclk);
    chk_bit($sformatf("out%0d", idx), e, outs[idx]);
    @(posedge i_mclk);
  endtask : wait_out
  task automatic put(input int sl, input int v, input int o);
    i_voltage <= 16'((sl == 1) ? v : o);
    i_current <= 16'((sl == 2) ? v : o);
    i_power   <= 16'((sl == 3) ? v : o);
  endtask : put
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // read data stand in the cycle after the strobe only
  always @(posedge i_mclk)
    rd_d <= i_rd;
  always @(negedge i_mclk)
  begin
    if (rd_d === 1'b1)
    begin
      exp_n = exp_q.pop_front();
      chk_word(exp_n[31:0], o_rdata & exp_n[63:32]);
    end
  end
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  // ********************************
  // scenarios
  // ********************************
  initial
  begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {3'b100, 40'h0};
    {i_voltage, i_current, i_power} = 48'h0;
    {cmd_on, cmd_rdy, cmd_warn} = 3'b011;
    void'($urandom(66723));
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rd(lsrc_pkg::OFS_CTRL, 32'h0, 32'hffffffff);
    rd(lsrc_pkg::OFS_IRQ_MASK, 32'h0, 32'hffffffff);
    wr(8'h40, 32'h5a);
    rd(8'h40, 32'h0, 32'hffffffff);
    wait_out(0, 1'b1, 8);
    wait_out(2, 1'b1, 8);
    wr(lsrc_pkg::OFS_CTRL, 32'h80);
    wait_out(0, 1'b0, 8);
    wr(lsrc_pkg::OFS_CTRL, 32'h0);
    cmd_warn <= 1'b0;
    wait_out(2, 1'b0, 8);
    wr(lsrc_pkg::OFS_IRQ_MASK, 32'h4);
    cmd_on <= 1'b1;
    wait_out(3, 1'b1, 8);
    wait_out(1, 1'b1, 8);
    wait_out(4, 1'b1, 4);
    rd(lsrc_pkg::OFS_IRQ_STATUS, 32'h4, 32'h4);
    wait_out(4, 1'b0, 4);
    cmd_on <= 1'b0;
    wait_out(3, 1'b0, 8);
    wr(lsrc_pkg::OFS_UPPER_LIMIT, 32'(U));
    wr(lsrc_pkg::OFS_LOWER_LIMIT, {16'h0, 16'(L)});
    wr(lsrc_pkg::OFS_UPPER_HYST, 32'(H));
    wr(lsrc_pkg::OFS_LOWER_HYST, 32'(H));
    wr(lsrc_pkg::OFS_DELAY_ON, 32'h2);
    wr(lsrc_pkg::OFS_DELAY_OFF, 32'h1);
    wr(lsrc_pkg::OFS_IRQ_MASK, 32'h3);
    rd(lsrc_pkg::OFS_LOWER_LIMIT, {16'h0, 16'(L)}, 32'hffffffff);
    // each function on a quantity in turn, leave reusing voltage; the others take the opposite value
    for (int f = 0; f < 4; f++)
    begin
      s   = f % 3 + 1;
      rs  = (f == 3) ? 0 : f;
      lv  = f[0] ^ (f == 2);
      r   = $urandom_range(400, 1);
      act = (f == 1) ? L - r : (f == 2) ? L + r : U + r;
      ina = (f == 0) ? U - H - r : (f == 2) ? U + H + r : L + H + r;
      put(s, ina, act);
      wr(lsrc_pkg::OFS_CTRL,
         32'(s | f << 2 | rs << 4 | (f & 1) << 6 | (f == 2) << 7));
      wait_out(2 - rs, ~lv, 8);
      if (f == 0)
      begin
        put(s, act, ina);
        repeat (TK) @(posedge i_mclk);
        put(s, ina, act);
        repeat (4 * TK) @(posedge i_mclk);
        wait_out(2 - rs, ~lv, 0);
      end
      put(s, act, ina);
      wait_out(2 - rs, lv, 5 * TK);
      wait_out(4, 1'b1, 4);
      rd(lsrc_pkg::OFS_STATE, 32'h1, 32'h1);
      rd(lsrc_pkg::OFS_IRQ_STATUS, 32'h1, 32'h3);
      if (f == 0)
      begin
        put(s, U - H / 2, ina);
        repeat (3 * TK) @(posedge i_mclk);
        wait_out(2 - rs, lv, 0);
      end
      put(s, ina, act);
      wait_out(2 - rs, ~lv, 5 * TK);
      rd(lsrc_pkg::OFS_IRQ_STATUS, 32'h2, 32'h3);
      wait_out(4, 1'b0, 4);
      wr(lsrc_pkg::OFS_CTRL, 32'h0);
    end
    report_and_stop();
  end
endmodule : tb
